// *** verilog/clkgen_pkg.sv ***
package clkgen_pkg;
  // serial configuration framing
  localparam logic [7:0] SLAVE_ADDR_WR = 8'hD2;
  localparam logic [7:0] CMD_CODE = 8'h00;
  localparam int MAX_BYTE_COUNT = 32;
  localparam int CFG_BYTES = 3;
  // configuration byte 0 field positions
  localparam int B0_CPU2_EN = 0;
  localparam int B0_USB_EN = 1;
  localparam int B0_DOT_EN = 2;
  localparam int B0_SPREAD = 3;
  // power-up reset values of the configuration bytes (all enabled, no spread)
  localparam logic [7:0] CFG0_RST = 8'h07;
  localparam logic [7:0] CFG1_RST = 8'hFF;
  localparam logic [7:0] CFG2_RST = 8'hFE;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int STRAP_TIME_US = 2000;
  localparam int STRAP_CYCLES = STRAP_TIME_US * CLK_MHZ;
  localparam int LOCK_TIME_US = 1;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int SER_HALF_CYCLES = 125;
  // test-mode dividers of the overdriven test clock
  localparam int DIV_CPU = 4;
  localparam int DIV_66 = 6;
  localparam int DIV_PCI = 12;
  localparam int DIV_48 = 2;
  // operating modes decoded from strap and select pins
  typedef enum logic [2:0] {
    MODE_HIZ = 3'b000,
    MODE_TEST = 3'b001,
    MODE_CPU66 = 3'b010,
    MODE_CPU100 = 3'b011,
    MODE_RSVD = 3'b100,
    MODE_CPU133 = 3'b101
  } mode_t;
endpackage

// *** verilog/serial_cfg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-wire configuration link; sda is a wired-and of the enabled drivers, scl comes from the host alone
interface serial_cfg_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o) ? 1'b0 : 1'b1;
  modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// *** verilog/clkgen_device.sv ***
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module clkgen_device #(
  parameter int STRAP_CYCLES = clkgen_pkg::STRAP_CYCLES,
  parameter int LOCK_CYCLES = clkgen_pkg::LOCK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  serial_cfg_if.device link,
  input wire logic strap_pin_i,
  input wire logic func_select_lo,
  input wire logic func_select_hi,
  input wire logic power_down_n,
  input wire logic test_clock_in,
  output logic ref_out_strap_pin,
  output logic ref_out_strap_oe,
  output logic [2:0] cpu_clk,
  output logic [7:0] sdram_clk,
  output logic [1:0] fixed_66_outputs,
  output logic [7:0] pci_clk,
  output logic [1:0] intc_clock_outputs,
  output logic usb_clk,
  output logic dot_clk,
  output logic outputs_oe,
  output logic pll_on,
  output logic spread_on,
  output logic [2:0] mode_out
);
  logic [22:0] strap_cnt_reg;
  logic strap_done_reg;
  logic fsb_top_speed_strap;
  logic [1:0] strap_sync_reg, sel_lo_sync_reg, sel_hi_sync_reg, test_clock_in_sync_reg, pd_sync_reg;
  logic [1:0] pd_low_hist_reg;
  logic pd_active_reg;
  logic [15:0] lock_cnt_reg;
  logic locked_reg;
  logic test_clock_in_prev_reg;
  logic [3:0] div_cnt_reg;
  logic cpu_t_reg, c66_t_reg, pci_t_reg, c48_t_reg;
  logic [7:0] cfg_reg [clkgen_pkg::CFG_BYTES];
  clkgen_pkg::mode_t mode;

  // every pin enters through two flops before any logic sees it
  always_ff @(posedge clk_sys) begin
    strap_sync_reg <= {strap_sync_reg[0], strap_pin_i};
    sel_lo_sync_reg <= {sel_lo_sync_reg[0], func_select_lo};
    sel_hi_sync_reg <= {sel_hi_sync_reg[0], func_select_hi};
    test_clock_in_sync_reg <= {test_clock_in_sync_reg[0], test_clock_in};
    pd_sync_reg <= {pd_sync_reg[0], power_down_n};
  end

  // strap is sampled until the 2 ms window ends, then frozen
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
      fsb_top_speed_strap <= 1'b0;
    end else if (!strap_done_reg) begin
      fsb_top_speed_strap <= strap_sync_reg[1];
      strap_cnt_reg <= strap_cnt_reg + 23'h000001;
      if (strap_cnt_reg == 23'(STRAP_CYCLES - 1)) begin
        strap_done_reg <= 1'b1;
      end
    end
  end

  // mode decode from strap and selects
  always_comb begin
    case ({sel_hi_sync_reg[1], sel_lo_sync_reg[1]})
      2'b00: mode = clkgen_pkg::MODE_HIZ;
      2'b01: mode = clkgen_pkg::MODE_TEST;
      2'b10: mode = fsb_top_speed_strap ? clkgen_pkg::MODE_RSVD : clkgen_pkg::MODE_CPU66;
      2'b11: mode = fsb_top_speed_strap ? clkgen_pkg::MODE_CPU133 : clkgen_pkg::MODE_CPU100;
      default: mode = clkgen_pkg::MODE_HIZ;
    endcase
  end

  // two successive low samples enter power-down; release waits for lock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pd_low_hist_reg <= 2'b00;
      pd_active_reg <= 1'b0;
      lock_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else begin
      pd_low_hist_reg <= {pd_low_hist_reg[0], ~pd_sync_reg[1]};
      if (pd_low_hist_reg == 2'b11) begin
        pd_active_reg <= 1'b1;
      end else if (pd_low_hist_reg == 2'b00) begin
        pd_active_reg <= 1'b0;
      end
      if (pd_active_reg) begin
        lock_cnt_reg <= '0;
        locked_reg <= 1'b0;
      end else if (!locked_reg) begin
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
        locked_reg <= (lock_cnt_reg == 16'(LOCK_CYCLES - 1));
      end
    end
  end

  // test mode: one shared divider on test clock edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      test_clock_in_prev_reg <= 1'b0;
      div_cnt_reg <= '0;
      cpu_t_reg <= 1'b0;
      c66_t_reg <= 1'b0;
      pci_t_reg <= 1'b0;
      c48_t_reg <= 1'b0;
    end else begin
      test_clock_in_prev_reg <= test_clock_in_sync_reg[1];
      if (test_clock_in_sync_reg[1] && !test_clock_in_prev_reg) begin
        div_cnt_reg <= (div_cnt_reg == 4'(clkgen_pkg::DIV_PCI - 1)) ? 4'h0 : div_cnt_reg + 4'h1;
        c48_t_reg <= ~c48_t_reg;
        if (div_cnt_reg[0]) begin
          cpu_t_reg <= ~cpu_t_reg;
        end
        if (div_cnt_reg == 4'h2 || div_cnt_reg == 4'h5 || div_cnt_reg == 4'h8
            || div_cnt_reg == 4'hB) begin
          c66_t_reg <= ~c66_t_reg;
        end
        if (div_cnt_reg == 4'h5 || div_cnt_reg == 4'hB) begin
          pci_t_reg <= ~pci_t_reg;
        end
      end
    end
  end

  // outputs: gated by power-down, lock, enables; the analog PLL clocks are modeled as levels
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_out_strap_pin <= 1'b0;
      ref_out_strap_oe <= 1'b0;
      cpu_clk <= '0;
      sdram_clk <= '0;
      fixed_66_outputs <= '0;
      pci_clk <= '0;
      intc_clock_outputs <= '0;
      usb_clk <= 1'b0;
      dot_clk <= 1'b0;
      outputs_oe <= 1'b0;
      pll_on <= 1'b0;
      spread_on <= 1'b0;
      mode_out <= 3'b000;
    end else begin
      logic run;
      logic tst;
      logic cpu_v;
      run = strap_done_reg && !pd_active_reg && locked_reg
            && mode != clkgen_pkg::MODE_RSVD;
      tst = (mode == clkgen_pkg::MODE_TEST);
      mode_out <= mode;
      pll_on <= !pd_active_reg;
      // spread only on PLL clocks, never the 48 MHz domain
      spread_on <= cfg_reg[0][clkgen_pkg::B0_SPREAD] && run && !tst;
      // select 00 floats every output, also while the strap is still sampled
      outputs_oe <= (mode != clkgen_pkg::MODE_HIZ);
      ref_out_strap_oe <= strap_done_reg && mode != clkgen_pkg::MODE_HIZ;
      ref_out_strap_pin <= run && (tst ? test_clock_in_sync_reg[1] : 1'b1);
      cpu_v = run && (tst ? cpu_t_reg : 1'b1);
      // CPU phase relative to SDRAM flagged by inversion at 100 MHz
      cpu_clk[1:0] <= {2{cpu_v ^ (run && mode == clkgen_pkg::MODE_CPU100)}};
      cpu_clk[2] <= (cpu_v ^ (run && mode == clkgen_pkg::MODE_CPU100))
                    && cfg_reg[0][clkgen_pkg::B0_CPU2_EN];
      sdram_clk <= {8{run && (tst ? cpu_t_reg : 1'b1)}} & cfg_reg[1];
      fixed_66_outputs <= {2{run && (tst ? c66_t_reg : 1'b1)}};
      pci_clk <= {{7{run && (tst ? pci_t_reg : 1'b1)}} & cfg_reg[2][7:1],
                  run && (tst ? pci_t_reg : 1'b1)};
      intc_clock_outputs <= {2{run && (tst ? pci_t_reg : 1'b1)}};
      usb_clk <= run && (tst ? c48_t_reg : 1'b1) && cfg_reg[0][clkgen_pkg::B0_USB_EN];
      dot_clk <= run && (tst ? c48_t_reg : 1'b1) && cfg_reg[0][clkgen_pkg::B0_DOT_EN];
    end
  end

  // serial block-write receiver
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_ADDR = 3'b001,
    RX_CMD = 3'b010,
    RX_COUNT = 3'b011,
    RX_DATA = 3'b100,
    RX_SKIP = 3'b101
  } rx_state_t;
  rx_state_t rx_state_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_prev_reg, sda_prev_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] byte_idx_reg;
  logic [5:0] remain_reg;

  always_ff @(posedge clk_sys) begin
    scl_sync_reg <= {scl_sync_reg[0], link.scl};
    sda_sync_reg <= {sda_sync_reg[0], link.sda};
  end

  // bit shifter and acknowledge driver
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_state_reg <= RX_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sh_reg <= '0;
      bit_cnt_reg <= '0;
      byte_idx_reg <= '0;
      remain_reg <= '0;
      link.sda_dev_o <= 1'b1;
      link.sda_dev_oe <= 1'b0;
      cfg_reg[0] <= clkgen_pkg::CFG0_RST;
      cfg_reg[1] <= clkgen_pkg::CFG1_RST;
      cfg_reg[2] <= clkgen_pkg::CFG2_RST;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
      if (scl_sync_reg[1] && sda_prev_reg && !sda_sync_reg[1]) begin
        rx_state_reg <= RX_ADDR; // start
        bit_cnt_reg <= '0;
        link.sda_dev_oe <= 1'b0;
      end else if (scl_sync_reg[1] && !sda_prev_reg && sda_sync_reg[1]) begin
        rx_state_reg <= RX_IDLE; // stop: bytes so far are kept
        link.sda_dev_oe <= 1'b0;
      end else if (scl_sync_reg[1] && !scl_prev_reg && rx_state_reg != RX_IDLE
                   && bit_cnt_reg < 4'h8) begin
        sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (!scl_sync_reg[1] && scl_prev_reg && rx_state_reg != RX_IDLE) begin
        if (bit_cnt_reg == 4'h8) begin
          bit_cnt_reg <= 4'h9;
          case (rx_state_reg)
            RX_ADDR: begin
              if (sh_reg == clkgen_pkg::SLAVE_ADDR_WR) begin
                rx_state_reg <= RX_CMD;
                link.sda_dev_oe <= 1'b1;
                link.sda_dev_o <= 1'b0;
              end else begin
                rx_state_reg <= RX_SKIP;
              end
            end
            RX_CMD: begin
              rx_state_reg <= RX_COUNT; // value ignored
              link.sda_dev_oe <= 1'b1;
              link.sda_dev_o <= 1'b0;
            end
            RX_COUNT: begin
              remain_reg <= sh_reg[5:0];
              byte_idx_reg <= '0;
              rx_state_reg <= (sh_reg == 8'h00) ? RX_SKIP : RX_DATA;
              link.sda_dev_oe <= 1'b1;
              link.sda_dev_o <= 1'b0;
            end
            RX_DATA: begin
              if (byte_idx_reg < 6'(clkgen_pkg::CFG_BYTES)) begin
                cfg_reg[byte_idx_reg[1:0]] <= sh_reg; // ascending
              end
              byte_idx_reg <= byte_idx_reg + 6'h01;
              remain_reg <= remain_reg - 6'h01;
              if (remain_reg == 6'h01) begin
                rx_state_reg <= RX_SKIP;
              end
              link.sda_dev_oe <= 1'b1;
              link.sda_dev_o <= 1'b0;
            end
            default: rx_state_reg <= RX_SKIP;
          endcase
        end else if (bit_cnt_reg == 4'h9) begin
          bit_cnt_reg <= '0;
          link.sda_dev_oe <= 1'b0;
          link.sda_dev_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/clkgen_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// core-logic side: APB registers drive a two-wire block write
module clkgen_host #(
  parameter int HALF_CYCLES = clkgen_pkg::SER_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  serial_cfg_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam logic [7:0] REG_CTRL = 8'h00; // bit0 go (write), bits 13:8 byte count
  localparam logic [7:0] REG_DATA = 8'h04; // bytes 0..3 little-endian
  localparam logic [7:0] REG_STAT = 8'h08; // bit0 busy, bit1 nack seen
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BITS = 3'b010,
    H_STOP = 3'b011,
    H_DONE = 3'b100
  } host_state_t;
  host_state_t st_reg;
  logic [5:0] count_reg;
  logic [31:0] data_reg;
  logic nack_reg;
  logic [7:0] tick_reg;
  logic tick;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [5:0] byte_reg;
  logic [7:0] cur_byte;
  logic [1:0] sda_sync_reg;

  // address, command, count, then data bytes lowest first
  function automatic logic [7:0] frame_byte(input logic [5:0] idx, input logic [5:0] cnt,
                                            input logic [31:0] d);
    case (idx)
      6'd0: frame_byte = clkgen_pkg::SLAVE_ADDR_WR;
      6'd1: frame_byte = clkgen_pkg::CMD_CODE;
      6'd2: frame_byte = {2'b00, cnt};
      6'd3: frame_byte = d[7:0];
      6'd4: frame_byte = d[15:8];
      6'd5: frame_byte = d[23:16];
      6'd6: frame_byte = d[31:24];
      default: frame_byte = 8'h00;
    endcase
  endfunction

  assign tick = (tick_reg == 8'(HALF_CYCLES - 1));
  assign cur_byte = frame_byte(byte_reg, count_reg, data_reg);

  always_ff @(posedge clk_sys) begin
    sda_sync_reg <= {sda_sync_reg[0], link.sda};
  end

  // APB slave, zero wait states; count clipped to 1..32
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      count_reg <= 6'h01;
      data_reg <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // writes land only at the completing access edge, never in setup
      if (psel && penable && pready && pwrite) begin
        if (paddr == REG_CTRL && st_reg == H_IDLE) begin
          count_reg <= (pwdata[13:8] == 6'h00) ? 6'h01
                       : (pwdata[13:8] > 6'h20) ? 6'h20 : pwdata[13:8];
        end else if (paddr == REG_DATA) begin
          data_reg <= pwdata;
        end
      end
      if (psel && !penable) begin
        prdata <= '0;
        if (!pwrite && paddr == REG_CTRL) begin
          prdata <= {18'h00000, count_reg, 8'h00};
        end else if (!pwrite && paddr == REG_DATA) begin
          prdata <= data_reg;
        end else if (!pwrite && paddr == REG_STAT) begin
          prdata <= {30'h00000000, nack_reg, st_reg != H_IDLE};
        end else if (paddr != REG_CTRL && paddr != REG_DATA && paddr != REG_STAT) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // serial sequencer: four quarter-phases per bit, block write only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= H_IDLE;
      tick_reg <= '0;
      phase_reg <= '0;
      bit_reg <= '0;
      byte_reg <= '0;
      nack_reg <= 1'b0;
      link.scl_o <= 1'b1;
      link.scl_oe <= 1'b0;
      link.sda_host_o <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end else begin
      tick_reg <= (tick || st_reg == H_IDLE) ? 8'h00 : tick_reg + 8'h01;
      case (st_reg)
        H_IDLE: begin
          if (psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[0]) begin
            st_reg <= H_START;
            nack_reg <= 1'b0;
            byte_reg <= '0;
            bit_reg <= '0;
            phase_reg <= '0;
            link.scl_oe <= 1'b1;
            link.sda_host_oe <= 1'b1;
          end
        end
        H_START: if (tick) begin
          link.sda_host_o <= 1'b0;
          st_reg <= H_BITS;
        end
        H_BITS: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          case (phase_reg)
            2'd0: begin
              link.scl_o <= 1'b0;
            end
            2'd1: begin
              link.sda_host_o <= (bit_reg == 4'h8) ? 1'b1 : cur_byte[3'(7 - bit_reg)];
            end
            2'd2: begin
              link.scl_o <= 1'b1;
            end
            default: begin
              if (bit_reg == 4'h8) begin
                bit_reg <= '0;
                if (sda_sync_reg[1]) begin
                  nack_reg <= 1'b1;
                  st_reg <= H_STOP;
                end else if (byte_reg == count_reg + 6'h02) begin
                  st_reg <= H_STOP;
                end else begin
                  byte_reg <= byte_reg + 6'h01;
                end
              end else begin
                bit_reg <= bit_reg + 4'h1;
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          case (phase_reg)
            2'd0: link.scl_o <= 1'b0;
            2'd1: link.sda_host_o <= 1'b0;
            2'd2: link.scl_o <= 1'b1;
            default: begin
              link.sda_host_o <= 1'b1;
              st_reg <= H_DONE;
            end
          endcase
        end
        H_DONE: if (tick) begin
          link.scl_oe <= 1'b0;
          link.sda_host_oe <= 1'b0;
          st_reg <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/clkgen_link_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module clkgen_link_sva #(
  parameter int STRAP_CYCLES = clkgen_pkg::STRAP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic power_down_n,
  input wire logic [2:0] mode_out,
  input wire logic outputs_oe,
  input wire logic pll_on,
  input wire logic ref_out_strap_oe,
  input wire logic [2:0] cpu_clk,
  input wire logic [7:0] sdram_clk,
  input wire logic [7:0] pci_clk
);
  // one ack lasts a bit period; bound sized for the short bench half period
  localparam int ACK_MAX = 40;
  logic [31:0] since_rst;
  logic dev_ack;
  assign dev_ack = sda_dev_oe & ~sda_dev_o;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // age since reset release, saturating so a long run never wraps it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) since_rst <= 32'h0;
    else if (since_rst != 32'hFFFFFFFF) since_rst <= since_rst + 32'h1;
  end
  AST_STRAP_WINDOW: assert property (
    ref_out_strap_oe |-> since_rst >= STRAP_CYCLES - 1) else $error("strap pin driven early");
  AST_HIZ_ALL: assert property (
    (mode_out == clkgen_pkg::MODE_HIZ)[*2] |-> !outputs_oe) else $error("outputs driven in hiz");
  AST_NORMAL_ON: assert property (
    (pll_on && mode_out inside {clkgen_pkg::MODE_CPU66, clkgen_pkg::MODE_CPU100,
      clkgen_pkg::MODE_CPU133})[*2] |-> outputs_oe) else $error("normal mode not driven");
  AST_RSVD_LOW: assert property (
    (mode_out == clkgen_pkg::MODE_RSVD)[*2] |-> cpu_clk == 3'h0 && sdram_clk == 8'h00
      && pci_clk == 8'h00) else $error("reserved mode outputs not low");
  AST_PD_STOP: assert property (
    (!power_down_n)[*8] |-> !pll_on && cpu_clk == 3'h0 && sdram_clk == 8'h00)
    else $error("power down did not stop outputs");
  AST_PD_SYNCED: assert property (
    $fell(power_down_n) && pll_on |=> pll_on) else $error("power down acted unsynchronised");
  AST_CPU100_PHASE: assert property (
    (pll_on && mode_out == clkgen_pkg::MODE_CPU100 && sdram_clk[0])[*3] |-> !cpu_clk[0])
    else $error("cpu not inverted against sdram");
  AST_ACK_IN_LOW: assert property (
    $rose(dev_ack) |-> !scl) else $error("ack started with scl high");
  AST_ACK_ENDS: assert property (
    $rose(dev_ack) |-> ##[1:ACK_MAX] !dev_ack) else $error("ack held too long");
  AST_QUIET_AFTER_RESET: assert property (
    $fell(sys_rst) |-> !sda_dev_oe) else $error("device drives data after reset");
  cover property ($rose(dev_ack));
  cover property (mode_out == clkgen_pkg::MODE_TEST && cpu_clk[0]);
  cover property ($fell(pll_on));
  cover property (!outputs_oe && since_rst > 32'h64);
endmodule
`default_nettype wire

// *** testbench/fsb_clock_gen_control_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module fsb_clock_gen_control_bench;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic strap_pin_i, func_select_lo, func_select_hi, power_down_n, test_clock_in, er;
  logic ref_out_strap_pin, ref_out_strap_oe, usb_clk, dot_clk, outputs_oe, pll_on, spread_on;
  logic [2:0] cpu_clk, mode_out;
  logic [7:0] sdram_clk, pci_clk;
  logic [1:0] fixed_66_outputs, intc_clock_outputs;
  logic [5:0] prv, cur;
  int failures, checks;
  int cnt[6];
  int texp[6] = '{12, 8, 4, 4, 24, 48};
  serial_cfg_if link_if();
  clkgen_device #(.STRAP_CYCLES(20), .LOCK_CYCLES(4)) clkgen_device_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .link(link_if), .strap_pin_i(strap_pin_i),
    .func_select_lo(func_select_lo), .func_select_hi(func_select_hi),
    .power_down_n(power_down_n), .test_clock_in(test_clock_in),
    .ref_out_strap_pin(ref_out_strap_pin), .ref_out_strap_oe(ref_out_strap_oe),
    .cpu_clk(cpu_clk), .sdram_clk(sdram_clk), .fixed_66_outputs(fixed_66_outputs),
    .pci_clk(pci_clk), .intc_clock_outputs(intc_clock_outputs), .usb_clk(usb_clk),
    .dot_clk(dot_clk), .outputs_oe(outputs_oe), .pll_on(pll_on), .spread_on(spread_on),
    .mode_out(mode_out));
  clkgen_host #(.HALF_CYCLES(4)) clkgen_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link_if), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  clkgen_link_sva #(.STRAP_CYCLES(20)) clkgen_link_sva_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .scl(link_if.scl), .sda_dev_o(link_if.sda_dev_o),
    .sda_dev_oe(link_if.sda_dev_oe), .power_down_n(power_down_n), .mode_out(mode_out),
    .outputs_oe(outputs_oe), .pll_on(pll_on), .ref_out_strap_oe(ref_out_strap_oe),
    .cpu_clk(cpu_clk), .sdram_clk(sdram_clk), .pci_clk(pci_clk));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task print_verdict();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // edge counts are allowed one off, the synchroniser shifts the window start
  task chkn(input int got, input int exp);
    checks++;
    if (got < exp - 1 || got > exp + 1) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask
  task wait_pll();
    int n;
    n = 0;
    // outputs run only after the strap window and the lock count
    while ((pll_on !== 1'b1 || ref_out_strap_oe !== 1'b1) && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (pll_on !== 1'b1 || ref_out_strap_oe !== 1'b1) begin
      failures++;
      print_verdict();
    end
    tick(8);
  endtask
  task restart(input logic s, input logic [1:0] sel);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    strap_pin_i <= s;
    func_select_hi <= sel[1];
    func_select_lo <= sel[0];
    tick(3);
    sys_rst <= 1'b0;
    wait_pll();
  endtask
  task set_sel(input logic [1:0] sel);
    func_select_hi <= sel[1];
    func_select_lo <= sel[0];
    tick(8);
  endtask
  // block write of count bytes; busy is polled with a bounded loop
  task send_cfg(input logic [31:0] data, input logic [5:0] count);
    int n;
    apb(1'b1, 8'h04, data);
    apb(1'b1, 8'h00, {18'h0, count, 8'h01});
    tick(4);
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 1000);
    if (rd[0] !== 1'b0) begin
      failures++;
      print_verdict();
    end
    chk(rd[1:0], 32'h0);
    tick(10);
  endtask
  initial begin
    failures = 0;
    checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {strap_pin_i, func_select_hi, func_select_lo} = 3'h7;
    test_clock_in = 1'b0;
    power_down_n = 1'b1;
    sys_rst = 1'b1;
    restart(1'b1, 2'b11);
    chk(mode_out, clkgen_pkg::MODE_CPU133);
    chk({ref_out_strap_oe, outputs_oe}, 32'h3);
    set_sel(2'b10);
    chk({cpu_clk, sdram_clk, pci_clk}, 32'h0);
    set_sel(2'b00);
    chk(outputs_oe, 32'h0);
    set_sel(2'b01);
    chk(mode_out, clkgen_pkg::MODE_TEST);
    cnt = '{default: 0};
    prv = {ref_out_strap_pin, usb_clk, intc_clock_outputs[0], pci_clk[0],
      fixed_66_outputs[0], cpu_clk[0]};
    for (int i = 0; i < 384; i++) begin
      @(posedge clk_sys);
      if (i % 8 == 0) test_clock_in <= ~test_clock_in;
      cur = {ref_out_strap_pin, usb_clk, intc_clock_outputs[0], pci_clk[0],
        fixed_66_outputs[0], cpu_clk[0]};
      for (int k = 0; k < 6; k++) if (cur[k] !== prv[k]) cnt[k]++;
      prv = cur;
    end
    for (int k = 0; k < 6; k++) chkn(cnt[k], texp[k]);
    restart(1'b0, 2'b11);
    chk(mode_out, clkgen_pkg::MODE_CPU100);
    chk(cpu_clk[0] ^ sdram_clk[0], 32'h1);
    set_sel(2'b10);
    chk(mode_out, clkgen_pkg::MODE_CPU66);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 32'h1);
    send_cfg(32'h00020F0E, 6'd3);
    chk({spread_on, usb_clk, dot_clk, cpu_clk}, 32'h3B);
    chk({sdram_clk, pci_clk}, 32'h0F03);
    // a one-byte transfer must leave bytes 1 and 2 untouched
    send_cfg(32'h00000007, 6'd1);
    chk({spread_on, cpu_clk, sdram_clk}, 32'h70F);
    @(posedge clk_sys);
    power_down_n <= 1'b0;
    tick(12);
    chk({pll_on, cpu_clk, sdram_clk, usb_clk}, 32'h0);
    power_down_n <= 1'b1;
    wait_pll();
    chk({spread_on, sdram_clk, pci_clk}, 32'h0F03);
    print_verdict();
  end
endmodule
`default_nettype wire
